// ==== rtl/see_eeprom.sv ====
// two-wire serial eeprom slave: page write, ack polling, reads
// assumes scl/sda arrive as raw pins; link_clk_i oversamples them
// Notes on behaviour
// - a write transaction accepts up to eight data bytes as one page
// - each data byte is acked and only address bits 2:0 advance
// - passing the last byte of a page wraps to its first byte
// - beyond eight bytes the page keeps wrapping and overwrites
// - stop after data starts programming; buffered bytes commit together when it ends
// - start and address bytes are still decoded while programming runs
// - slave address is not acked while programming runs
// - slave address is acked again once programming finished
// - address counter holds last accessed location plus one
// - read address is acked, then byte at counter is sent
// - counter past top wraps so reading returns location zero
// - dummy write programs nothing; read returns loaded address
// - each master ack advances counter and sends next byte
// - sequential read wraps from top location to zero seamlessly
// - respond only to type code plus matching select pins
// - array is 128 or 256 bytes, sizing the address counter
// - write protect high blocks every array write
`timescale 1ns/1ps
`include "see_params.svh"

module see_eeprom #(
  parameter int MEM_BYTES = `SEE_MEM_BYTES,
  parameter int WR_CYCLES = `SEE_TWR_MS * 1000 * `SEE_CLK_MHZ
) (
  // system clock
  input wire logic clk_i,
  input wire logic nrst_i,
  // link sampling clock
  input wire logic link_clk_i,
  // two-wire bus, open drain data
  input wire see_pkg::see_line_t line_i,
  output logic sda_o,
  output logic sda_oe_o,
  // strap pins
  input wire logic addr_select_pin0_i,
  input wire logic addr_select_pin1_i,
  input wire logic addr_select_pin2_i,
  input wire logic wp_i,
  // status
  output logic busy_o
);
  import see_pkg::*;

  localparam int ADDR_W = $clog2(MEM_BYTES);
  localparam int PB = `SEE_PAGE_BITS;
  localparam int PAGE = 1 << PB;
  localparam logic [ADDR_W-1:0] TOP = ADDR_W'(MEM_BYTES - 1);

  // =====================================================================
  // declarations
  see_line_t line_m_q;
  see_line_t line_s_q;
  see_line_t line_p_q;
  see_strap_t strap_m_q;
  see_strap_t strap_s_q;
  logic done_m_q;
  logic done_s_q;
  logic done_p_q;
  logic done_tgl;
  see_state_t state_q;
  see_kind_t kind_q;
  logic [3:0] cnt_q;
  logic [7:0] shreg_q;
  logic rw_q;
  logic mack_q;
  logic sda_oe_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] tx_q;
  logic busy_q;
  logic go_tgl_q;
  logic wr_pend_q;
  logic [ADDR_W-PB-1:0] page_q;
  logic [7:0] mem_q [MEM_BYTES];
  logic [7:0] pg_data [PAGE];
  logic [PAGE-1:0] pg_vld;
  logic [7:0] rd_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic eval;
  logic eval_dev;
  logic eval_word;
  logic eval_data;
  logic dev_match;
  logic ack_fall;
  logic rd_load;
  logic commit;
  logic wr_ok;

  // =====================================================================
  // pin synchronisers; logic reads the second stage and its delayed third copy
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_m_q <= '{scl: 1'b1, sda: 1'b1};
      line_s_q <= '{scl: 1'b1, sda: 1'b1};
      line_p_q <= '{scl: 1'b1, sda: 1'b1};
      strap_m_q <= '0;
      strap_s_q <= '0;
    end else begin
      line_m_q <= line_i;
      line_s_q <= line_m_q;
      line_p_q <= line_s_q;
      strap_m_q <= '{wp: wp_i,
                     sel: {addr_select_pin2_i, addr_select_pin1_i, addr_select_pin0_i}};
      strap_s_q <= strap_m_q;
    end
  end

  // done toggle from the timer crosses back here
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_m_q <= 1'b0;
      done_s_q <= 1'b0;
      done_p_q <= 1'b0;
    end else begin
      done_m_q <= done_tgl;
      done_s_q <= done_m_q;
      done_p_q <= done_s_q;
    end
  end

  // =====================================================================
  // bus events; start/stop seen as sda moving while scl stays high
  assign scl_rise = line_s_q.scl & ~line_p_q.scl;
  assign scl_fall = ~line_s_q.scl & line_p_q.scl;
  assign start_det = line_s_q.scl & line_p_q.scl & line_p_q.sda & ~line_s_q.sda;
  assign stop_det = line_s_q.scl & line_p_q.scl & ~line_p_q.sda & line_s_q.sda;
  assign eval = scl_fall && state_q == ST_RX && cnt_q == `SEE_BYTE_BITS;
  assign eval_dev = eval && kind_q == K_DEV;
  assign eval_word = eval && kind_q == K_WORD;
  assign eval_data = eval && kind_q == K_DATA;
  assign dev_match = shreg_q[7:4] == `SEE_TYPE_CODE && shreg_q[3:1] == strap_s_q.sel;
  assign ack_fall = scl_fall && state_q == ST_ACK;
  assign rd_load = (ack_fall && rw_q) || (scl_fall && state_q == ST_MACK && mack_q);
  assign commit = done_s_q ^ done_p_q;
  assign wr_ok = ~strap_s_q.wp;
  assign rd_byte = mem_q[addr_q];

  // =====================================================================
  // byte engine: receive, acknowledge, transmit, master ack slot
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      kind_q <= K_DEV;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (start_det) begin
      state_q <= ST_RX; // repeated start also lands here
      kind_q <= K_DEV;
      cnt_q <= 4'h0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise && cnt_q != `SEE_BYTE_BITS) begin
            shreg_q <= {shreg_q[6:0], line_s_q.sda};
            cnt_q <= cnt_q + 4'h1;
          end else if (eval_dev) begin
            if (dev_match && !busy_q) begin
              state_q <= ST_ACK;
              rw_q <= shreg_q[0];
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (eval) begin
            state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (ack_fall) begin
            cnt_q <= rw_q ? 4'h1 : 4'h0;
            state_q <= rw_q ? ST_TX : ST_RX;
            kind_q <= (kind_q == K_DEV) ? K_WORD : K_DATA;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == `SEE_BYTE_BITS) begin
              state_q <= ST_MACK;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_q <= ~line_s_q.sda;
          end else if (scl_fall) begin
            cnt_q <= 4'h1;
            state_q <= mack_q ? ST_TX : ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE; // wait for the next start
        end
      endcase
    end
  end

  // =====================================================================
  // data line drive: ack low, read bits msb first, released otherwise
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_oe_q <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe_q <= 1'b0;
    end else if (eval_dev) begin
      sda_oe_q <= dev_match & ~busy_q;
    end else if (eval) begin
      sda_oe_q <= 1'b1;
    end else if (rd_load) begin
      sda_oe_q <= ~rd_byte[7];
    end else if (scl_fall && state_q == ST_TX && cnt_q != `SEE_BYTE_BITS) begin
      sda_oe_q <= ~tx_q[~cnt_q[2:0]];
    end else if (scl_fall) begin
      sda_oe_q <= 1'b0; // end of ack slot or of last read bit
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_q;

  // =====================================================================
  // address counter: loaded by word address, page wrap on writes,
  // full wrap on reads; narrow arrays simply drop the high bit
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_q <= '0;
    end else if (eval_word) begin
      addr_q <= shreg_q[ADDR_W-1:0];
    end else if (eval_data) begin
      addr_q[PB-1:0] <= addr_q[PB-1:0] + PB'(1);
    end else if (rd_load) begin
      addr_q <= (addr_q == TOP) ? '0 : addr_q + ADDR_W'(1);
    end
  end

  // read shift register, loaded with the byte under the counter
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_q <= 8'h00;
    end else if (rd_load) begin
      tx_q <= rd_byte;
    end
  end

  // =====================================================================
  // page buffer, one entry per byte of a page; later bytes overwrite
  for (genvar i = 0; i < PAGE; i++) begin : g_page
    logic [7:0] data_q;
    logic vld_q;
    always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        data_q <= 8'h00;
        vld_q <= 1'b0;
      end else if (commit || (start_det && !busy_q)) begin
        vld_q <= 1'b0;
      end else if (eval_data && wr_ok && addr_q[PB-1:0] == PB'(i)) begin
        data_q <= shreg_q;
        vld_q <= 1'b1;
      end
    end
    assign pg_data[i] = data_q;
    assign pg_vld[i] = vld_q;
  end

  // =====================================================================
  // write cycle control; busy is set locally so polling right after
  // stop is refused without waiting for the crossing
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_q <= 1'b0;
      go_tgl_q <= 1'b0;
      wr_pend_q <= 1'b0;
      page_q <= '0;
    end else if (commit) begin
      busy_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (stop_det && wr_pend_q && !busy_q) begin
      busy_q <= 1'b1;
      go_tgl_q <= ~go_tgl_q;
      page_q <= addr_q[ADDR_W-1:PB];
    end else if (start_det && !busy_q) begin
      wr_pend_q <= 1'b0; // data without stop is dropped
    end else if (eval_data && wr_ok) begin
      wr_pend_q <= 1'b1;
    end
  end

  assign busy_o = busy_q;

  // one write cycle commits every buffered byte of the page
  always_ff @(posedge link_clk_i) begin
    if (commit) begin
      for (int j = 0; j < PAGE; j++) begin
        if (pg_vld[j]) begin
          mem_q[{page_q, PB'(j)}] <= pg_data[j];
        end
      end
    end
  end

  // =====================================================================
  // programming delay on the system clock
  see_wr_timer #(
    .WR_CYCLES(WR_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .go_tgl_i(go_tgl_q),
    .done_tgl_o(done_tgl)
  );

  // =====================================================================
  // checks
  property p_busy_nak;
    @(posedge link_clk_i) disable iff (!nrst_i)
    (eval_dev && busy_q) |=> (!sda_oe_q && state_q == ST_IDLE);
  endproperty
  a_busy_nak: assert property (p_busy_nak) else $error("address acked while busy");

  property p_dev_ack;
    @(posedge link_clk_i) disable iff (!nrst_i)
    (eval_dev && dev_match && !busy_q) |=> (sda_oe_q && state_q == ST_ACK);
  endproperty
  a_dev_ack: assert property (p_dev_ack) else $error("matching address not acked");

  property p_foreign;
    @(posedge link_clk_i) disable iff (!nrst_i)
    (eval_dev && !dev_match) |=> !sda_oe_q;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address acked");

  property p_page_step;
    @(posedge link_clk_i) disable iff (!nrst_i)
    eval_data |=> (addr_q[PB-1:0] == $past(addr_q[PB-1:0]) + PB'(1)
                   && addr_q[ADDR_W-1:PB] == $past(addr_q[ADDR_W-1:PB]) && sda_oe_q);
  endproperty
  a_page_step: assert property (p_page_step) else $error("page address step wrong");

  property p_stop_prog;
    @(posedge link_clk_i) disable iff (!nrst_i)
    (stop_det && wr_pend_q && !busy_q && !commit) |=> busy_q ##1 busy_q;
  endproperty
  a_stop_prog: assert property (p_stop_prog) else $error("stop did not start write");

  property p_protect;
    @(posedge link_clk_i) disable iff (!nrst_i)
    (eval_data && !wr_ok && !commit) |=> ($stable(pg_vld) && wr_pend_q == $past(wr_pend_q));
  endproperty
  a_protect: assert property (p_protect) else $error("protected write buffered");

  property p_read_load;
    @(posedge link_clk_i) disable iff (!nrst_i)
    rd_load |=> (tx_q == $past(rd_byte) && sda_oe_q == ~tx_q[7]);
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte not loaded");

  property p_read_wrap;
    @(posedge link_clk_i) disable iff (!nrst_i)
    (rd_load && addr_q == TOP) |=> addr_q == '0;
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("counter did not wrap");

  property p_commit_free;
    @(posedge link_clk_i) disable iff (!nrst_i)
    commit |=> (!busy_q && pg_vld == '0 && !wr_pend_q);
  endproperty
  a_commit_free: assert property (p_commit_free) else $error("commit left state");

endmodule

// ==== inc/see_params.svh ====
// constants of the serial eeprom engine: type code, sizes, timing
// assumes inclusion by bare name from any file that needs a figure
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH

// =====================================================================
// addressing
`define SEE_TYPE_CODE 4'ha
`define SEE_MEM_BYTES 256
`define SEE_PAGE_BITS 3
`define SEE_BYTE_BITS 4'h8

// =====================================================================
// timing
`define SEE_TWR_MS 5
`define SEE_CLK_MHZ 250

`endif

// ==== inc/see_pkg.sv ====
// types shared by the serial eeprom engine and its write timer
// assumes nothing beyond a SystemVerilog compiler
package see_pkg;

  // =====================================================================
  // bus engine states and byte kinds
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} see_state_t;
  typedef enum logic [1:0] {K_DEV, K_WORD, K_DATA} see_kind_t;

  // =====================================================================
  // pin bundles
  typedef struct packed {
    logic scl;
    logic sda;
  } see_line_t;

  typedef struct packed {
    logic wp;
    logic [2:0] sel;
  } see_strap_t;

endpackage

// ==== rtl/see_wr_timer.sv ====
// self-timed programming delay of the serial eeprom, system clock side
// assumes a start toggle from the link domain; returns a done toggle
`timescale 1ns/1ps
`include "see_params.svh"

module see_wr_timer #(
  parameter int WR_CYCLES = `SEE_TWR_MS * 1000 * `SEE_CLK_MHZ
) (
  // system clock
  input wire logic clk_i,
  input wire logic nrst_i,
  // crossing toggles
  input wire logic go_tgl_i,
  output logic done_tgl_o
);
  import see_pkg::*;

  localparam logic [31:0] LAST = 32'(WR_CYCLES - 1);

  logic go_m_q;
  logic go_s_q;
  logic go_p_q;
  logic run_q;
  logic [31:0] cnt_q;
  logic done_tgl_q;

  // =====================================================================
  // toggle synchroniser, edge taken after the second stage only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      go_m_q <= 1'b0;
      go_s_q <= 1'b0;
      go_p_q <= 1'b0;
    end else begin
      go_m_q <= go_tgl_i;
      go_s_q <= go_m_q;
      go_p_q <= go_s_q;
    end
  end

  // =====================================================================
  // programming delay counter; done flips once per started cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_q <= 1'b0;
      cnt_q <= 32'h0;
      done_tgl_q <= 1'b0;
    end else if (go_s_q ^ go_p_q) begin
      run_q <= 1'b1;
      cnt_q <= 32'h0;
    end else if (run_q) begin
      if (cnt_q == LAST) begin
        run_q <= 1'b0;
        done_tgl_q <= ~done_tgl_q;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign done_tgl_o = done_tgl_q;

  property p_delay_len;
    @(posedge clk_i) disable iff (!nrst_i)
    (done_tgl_q != $past(done_tgl_q)) |-> ($past(cnt_q) == LAST && !run_q);
  endproperty
  a_delay_len: assert property (p_delay_len) else $error("write delay ended early");

endmodule

// ==== tb/see_bus_master.sv ====
// behavioural two-wire bus master for the serial eeprom bench
// assumes sda has a pull-up and the device only ever pulls it low
`timescale 1ns/1ps

module see_bus_master #(
  parameter int QTR = 36
) (
  // bench clock, pacing only
  input wire logic clk_i,
  // device open drain data
  input wire logic sda_o_i,
  input wire logic sda_oe_i,
  // resolved bus levels
  output see_pkg::see_line_t line_o
);
  import see_pkg::*;

  logic m_scl = 1'b1;
  logic m_sda_low = 1'b0;

  // =====================================================================
  // wired-and with pull-up: released line reads high, never stale
  assign line_o = '{scl: m_scl, sda: ~(m_sda_low | (sda_oe_i & ~sda_o_i))};

  // quarter of an scl period, 144 ns keeps high and low above 4 link clocks
  task automatic tick();
    repeat (QTR) @(negedge clk_i);
  endtask

  // start and repeated start alike; extra tick lets a trailing ack release
  task automatic start();
    m_sda_low = 1'b0;
    tick();
    tick();
    m_scl = 1'b1;
    tick();
    m_sda_low = 1'b1;
    tick();
    m_scl = 1'b0;
    tick();
  endtask

  task automatic stop();
    m_sda_low = 1'b1;
    tick();
    m_scl = 1'b1;
    tick();
    m_sda_low = 1'b0;
    tick();
    tick();
  endtask

  // data set a quarter after scl falls, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    m_sda_low = ~b;
    tick();
    m_scl = 1'b1;
    tick();
    s = line_o.sda;
    tick();
    m_scl = 1'b0;
    tick();
  endtask

  // msb first, ninth slot released for the device ack
  task automatic put(input logic [7:0] d, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    acked = (s === 1'b0);
  endtask

  task automatic get(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~mack, s);
  endtask
endmodule

// ==== tb/serial_eeprom_page_write_read_engine_tb_top.sv ====
// self-checking bench of the serial eeprom: page write, polling, reads
// assumes see_bus_master as bus partner and a 2000-cycle write delay
`timescale 1ns/1ps
`include "see_params.svh"

module serial_eeprom_page_write_read_engine_tb_top;
  import see_pkg::*;

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic wp = 1'b0;
  logic [2:0] sel = 3'h3;
  see_line_t line;
  logic sda_o;
  logic sda_oe;
  logic busy;
  logic [7:0] exp_mem [256];
  int fails = 0;
  int compares = 0;

  // =====================================================================
  // clocks: link offset by a fraction so edges never line up
  always #2 clk = ~clk;
  always begin
    #1.3;
    forever #32 link_clk = ~link_clk;
  end

  see_eeprom #(.MEM_BYTES(256), .WR_CYCLES(2000)) dut (
    .clk_i(clk), .nrst_i(nrst), .link_clk_i(link_clk), .line_i(line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_pin0_i(sel[0]),
    .addr_select_pin1_i(sel[1]), .addr_select_pin2_i(sel[2]), .wp_i(wp), .busy_o(busy));

  see_bus_master #(.QTR(36)) m (.clk_i(clk), .sda_o_i(sda_o), .sda_oe_i(sda_oe), .line_o(line));

  // =====================================================================
  // shared transfers
  task automatic dev(input logic rw, output logic acked);
    m.start();
    m.put({`SEE_TYPE_CODE, sel, rw}, acked);
  endtask

  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] v0);
    logic k;
    dev(1'b0, k);
    `CHK("dev ack", 1'b1, k)
    m.put(a, k);
    `CHK("word ack", 1'b1, k)
    for (int i = 0; i < n; i++) begin
      m.put(8'(v0 + i), k);
      `CHK("data ack", 1'b1, k)
      if (!wp) exp_mem[{a[7:3], 3'(a[2:0] + i)}] = 8'(v0 + i);
    end
    m.stop();
    if (!wp) `CHK("busy set", 1'b1, busy)
  endtask

  // bounded wait for the programming delay to run out
  task automatic settle();
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clk);
    `CHK("busy clear", 1'b0, busy)
  endtask

  // random read loads the address by a dummy write; otherwise current
  task automatic rd(input logic [7:0] a, input int n, input logic rnd);
    logic k;
    logic [7:0] d;
    if (rnd) begin
      dev(1'b0, k);
      m.put(a, k);
      `CHK("dummy word ack", 1'b1, k)
    end
    dev(1'b1, k);
    `CHK("read ack", 1'b1, k)
    for (int i = 0; i < n; i++) begin
      m.get(i < n - 1, d);
      `CHK("read byte", exp_mem[8'(a + i)], d)
    end
    m.stop();
    if (rnd) `CHK("dummy programs nothing", 1'b0, busy)
  endtask

  // =====================================================================
  // scenarios
  task automatic t_addr();
    logic k;
    m.start();
    m.put({4'hb, sel, 1'b0}, k);
    `CHK("wrong type nack", 1'b0, k)
    m.stop();
    for (int j = 0; j < 3; j++) begin
      m.start();
      m.put({`SEE_TYPE_CODE, sel ^ 3'(1 << j), 1'b0}, k);
      `CHK("wrong select nack", 1'b0, k)
      m.stop();
    end
    $display("test addr done");
  endtask

  // ten bytes from mid page: wrap and overwrite inside the page
  task automatic t_page();
    logic k;
    wr(8'h13, 10, 8'h40);
    dev(1'b0, k);
    `CHK("poll while busy", 1'b0, k)
    m.stop();
    settle();
    dev(1'b0, k);
    `CHK("poll after write", 1'b1, k)
    m.stop();
    rd(8'h15, 1, 1'b0);
    rd(8'h10, 8, 1'b1);
    $display("test page done");
  endtask

  task automatic t_wrap();
    wr(8'h00, 1, 8'h5a);
    settle();
    wr(8'hfe, 2, 8'ha5);
    settle();
    rd(8'hff, 1, 1'b1);
    rd(8'h00, 1, 1'b0);
    rd(8'hfe, 3, 1'b1);
    $display("test wrap done");
  endtask

  // protected write is acked but must leave the old byte
  task automatic t_wp();
    wp = 1'b1;
    wr(8'h00, 1, 8'hc3);
    settle();
    wp = 1'b0;
    rd(8'h00, 1, 1'b1);
    $display("test protect done");
  endtask

  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // =====================================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge link_clk);
    @(negedge clk);
    t_addr();
    t_page();
    t_wrap();
    t_wp();
    stop_test();
  end

  // clean run needs about 85k cycles; a hang stops near 100k
  initial begin
    repeat (100000) @(negedge clk);
    fails++;
    stop_test();
  end
endmodule
